// ==== shared/eci_pkg.sv ====
// constants, field layouts and bus carriers for the ethernet controller register bank
// assumes an apb master on the peripheral clock and a mac/dma core beside it
//
// Functional notes
// - Aliases at +4 clear, +8 set, +C invert
// - Packet-pending reads one while counter is nonzero
// - Pending clears only via reset or decrement to zero
// - Direct writes never touch packet-pending flag
// - Receive activity sets on each fifo data store
// - Transmit done sets when status vector written
// - Transmit abort sets on any mac abort cause
// - Descriptor unavailable sets on descriptor overrun
// - Receive overflow sets on receive fifo overflow
// - Event flags stick until reset or a plain, clear or invert write
// - Every register resets to zero
package eci_pkg;

  // --------------------------------------------------------------------------
  // register map (byte addresses, low 16 bits of the window)
  // --------------------------------------------------------------------------
  localparam logic [15:0] ADDR_MAIN_CONTROL   = 16'h9000;
  localparam logic [15:0] ADDR_RX_BUF_SIZE    = 16'h9010;
  localparam logic [15:0] ADDR_TX_DESC_START  = 16'h9020;
  localparam logic [15:0] ADDR_RX_DESC_START  = 16'h9030;
  localparam logic [15:0] ADDR_HASH_LOW       = 16'h9040;
  localparam logic [15:0] ADDR_HASH_HIGH      = 16'h9050;
  localparam logic [15:0] ADDR_PMASK_LOW      = 16'h9060;
  localparam logic [15:0] ADDR_PMASK_HIGH     = 16'h9070;
  localparam logic [15:0] ADDR_PCHECKSUM      = 16'h9080;
  localparam logic [15:0] ADDR_POFFSET        = 16'h9090;
  localparam logic [15:0] ADDR_RX_FILTER      = 16'h90A0;
  localparam logic [15:0] ADDR_RX_WATERMARKS  = 16'h90B0;
  localparam logic [15:0] ADDR_IRQ_ENABLE     = 16'h90C0;
  localparam logic [15:0] ADDR_IRQ_REQUEST    = 16'h90D0;
  localparam logic [15:0] ADDR_PKT_COUNT      = 16'h90E0; // read-only counter view, no aliases

  localparam int          NUM_REGS            = 14;
  localparam logic [3:0]  BASE_INDEX_LSB      = 4'h4;      // address bits 7:4 pick the register

  // alias sub-address in bits 3:2
  localparam logic [1:0]  ALIAS_PLAIN         = 2'h0;
  localparam logic [1:0]  ALIAS_CLEAR         = 2'h1;
  localparam logic [1:0]  ALIAS_SET           = 2'h2;
  localparam logic [1:0]  ALIAS_INVERT        = 2'h3;

  // --------------------------------------------------------------------------
  // register indices (offset bits 7:4)
  // --------------------------------------------------------------------------
  localparam int IDX_MAIN_CONTROL = 0;
  localparam int IDX_RX_BUF_SIZE  = 1;
  localparam int IDX_TX_DESC      = 2;
  localparam int IDX_RX_DESC      = 3;
  localparam int IDX_PCHECKSUM    = 8;
  localparam int IDX_POFFSET      = 9;
  localparam int IDX_RX_WATERMARK = 11;
  localparam int IDX_IRQ_ENABLE   = 12;
  localparam int IDX_IRQ_REQUEST  = 13;

  // --------------------------------------------------------------------------
  // implemented-bit masks; unimplemented bits read zero
  // --------------------------------------------------------------------------
  localparam logic [31:0] MASK_MAIN_CONTROL = 32'hFFFF_A3B1;
  localparam logic [31:0] MASK_RX_BUF_SIZE  = 32'h0000_07F0;
  localparam logic [31:0] MASK_DESC_START   = 32'hFFFF_FFFC;
  localparam logic [31:0] MASK_LOW_HALF     = 32'h0000_FFFF;
  localparam logic [31:0] MASK_WATERMARKS   = 32'h00FF_00FF;
  localparam logic [31:0] MASK_RX_FILTER    = 32'h0000_DFFF;
  localparam logic [31:0] MASK_IRQ          = 32'h0000_63EF;
  localparam logic [31:0] MASK_FULL         = 32'hFFFF_FFFF;

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int BIT_PKT_COUNTER_DEC   = 0;  // main control, self-clearing strobe
  localparam int BIT_RX_OVERFLOW       = 0;
  localparam int BIT_RX_DESC_UNAVAIL   = 1;
  localparam int BIT_TX_ABORT          = 2;
  localparam int BIT_TX_DONE           = 3;
  localparam int BIT_RX_ACTIVITY       = 5;
  localparam int BIT_PACKET_PENDING    = 6;
  localparam int BIT_RX_DONE           = 7;
  localparam int BIT_FULL_WATERMARK    = 8;
  localparam int BIT_EMPTY_WATERMARK   = 9;
  localparam int BIT_RX_BUS_ERROR      = 13;
  localparam int BIT_TX_BUS_ERROR      = 14;

  localparam logic [31:0] RESET_VALUE  = 32'h0000_0000;
  localparam int          COUNT_WIDTH  = 8;

  // --------------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } eci_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } eci_apb_rsp_t;

  // one-cycle event strobes from the mac and buffer manager
  typedef struct packed {
    logic txBusError;
    logic rxBusError;
    logic emptyWatermark;
    logic fullWatermark;
    logic rxDone;
    logic packetStored;    // receive_buffer_manager fifo store
    logic transmit_done_flag;
    logic transmit_abort_flag;
    logic rxDescUnavail;
    logic rxOverflow;
  } eci_events_t;

endpackage

// ==== sim/eci_mac_model.sv ====
// stand-in for the mac and buffer manager event sources
// assumes the bench raises one request bit per event for one cycle
`timescale 1ns/10ps
module eci_mac_model (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic [9:0]           fire,
  output      eci_pkg::eci_events_t events
);
  import eci_pkg::*;
  // ----------------------------------------
  // event strobes
  // ----------------------------------------
  // registered so each strobe is synchronous to mclk and as wide as its fire request, as the bank expects
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      events <= '0;
    end else begin
      events <= eci_events_t'(fire);
    end
  end
endmodule

// ==== sim/eci_regs_checker.sv ====
// port-level checks for the ethernet register bank
// assumes one mclk domain and an async active-high rst
`timescale 1ns/10ps
module eci_regs_checker #(
  parameter int CountWidth = eci_pkg::COUNT_WIDTH  // counter width, carried for the bind
) (
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire eci_pkg::eci_apb_req_t apbReq,
  input wire eci_pkg::eci_apb_rsp_t apbRsp,
  input wire logic [31:0]           mainControl,
  input wire logic [31:0]           rxBufSize,
  input wire logic [63:0]           hashTable,
  input wire logic [63:0]           patternMask,
  input wire logic                  counterDecPulse,
  input wire logic                  irq
);
  import eci_pkg::*;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic setup;   // setup phase seen at this edge
  logic wrDone;  // write accepted at this edge
  assign setup  = apbReq.psel & ~apbReq.penable;
  assign wrDone = apbReq.psel & apbReq.penable & apbReq.pwrite & apbRsp.pready;
  // ----------------------------------------
  // bus timing
  // ----------------------------------------
  a_ready_follows: assert property (setup |=> apbRsp.pready)
    else $error("no ready after setup");
  a_ready_once: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("ready held too long");
  a_unmapped_err: assert property (setup && apbReq.paddr[15:8] != 8'h90 |=> apbRsp.pslverr && apbRsp.prdata == '0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (setup && apbReq.paddr[15:8] == 8'h90 && apbReq.paddr[7:4] <= 4'hD |=> !apbRsp.pslverr)
    else $error("mapped access refused");
  // ----------------------------------------
  // register effects
  // ----------------------------------------
  a_reset_zero: assert property (disable iff (1'b0) rst |-> !irq && mainControl == '0 && hashTable == '0)
    else $error("outputs not cleared in reset");
  a_copy_write: assert property (wrDone && apbReq.paddr == ADDR_RX_BUF_SIZE
    |-> ##2 rxBufSize == ($past(apbReq.pwdata, 2) & MASK_RX_BUF_SIZE))
    else $error("buffer size copy wrong");
  a_set_alias: assert property (wrDone && apbReq.paddr == (ADDR_HASH_LOW | 16'h0008)
    |-> ##2 hashTable[31:0] == ($past(hashTable[31:0], 2) | $past(apbReq.pwdata, 2)))
    else $error("set alias wrong");
  a_clr_alias: assert property (wrDone && apbReq.paddr == (ADDR_PMASK_LOW | 16'h0004)
    |-> ##2 patternMask[31:0] == ($past(patternMask[31:0], 2) & ~$past(apbReq.pwdata, 2)))
    else $error("clear alias wrong");
  a_dec_pulse: assert property (wrDone && apbReq.paddr == ADDR_MAIN_CONTROL && apbReq.pwdata[0]
    |-> ##[1:2] counterDecPulse)
    else $error("no decrement pulse");
endmodule

// ==== sim/eci_regs_tb_top.sv ====
// self-checking bench for the ethernet register bank
// assumes apb tasks below as the only bus master
`timescale 1ns/10ps
module eci_regs_tb_top;
  import eci_pkg::*;
  logic         mclk;      // bench clock
  logic         rst;       // async reset
  eci_apb_req_t apbReq;    // master request
  eci_apb_rsp_t apbRsp;    // slave answer
  eci_events_t  events;    // strobes from the model
  logic [9:0]   fire;      // event requests to the model
  logic         irq;       // interrupt level
  logic         lastErr;   // error flag of last transfer
  logic [31:0]  q;         // data of last transfer
  int           badCount;  // mismatches
  int           testsRun;  // comparisons
  int           cyc;       // cycles since start
  int           b;         // expected flag position
  logic [31:0]  txDesc;    // transmit descriptor start output
  logic [31:0]  rxDesc;    // receive descriptor start output
  logic [15:0]  pCks;      // pattern checksum output
  logic [15:0]  pOff;      // pattern offset output
  logic [31:0]  rxFilt;    // receive filter output
  logic [31:0]  rxWmark;   // watermark output
  eci_regs #(.CountWidth(8)) u_eci_regs (.mclk(mclk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .events(events), .mainControl(), .rxBufSize(), .txDescStart(txDesc), .rxDescStart(rxDesc), .hashTable(),
    .patternMask(), .patternChecksum(pCks), .patternOffset(pOff), .rxFilterConfig(rxFilt), .rxWatermarks(rxWmark),
    .counterDecPulse(), .irq(irq));
  eci_mac_model u_eci_mac_model (.mclk(mclk), .rst(rst), .fire(fire), .events(events));
  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // a hung handshake would otherwise stall forever
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 5000) begin
      badCount++;
      stopTest();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; an idle edge first so psel never moves twice in a step
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    // no wait limit here: only the watchdog ends a hung access
    do begin
      @(posedge mclk);
    end while (apbRsp.pready !== 1'b1);
    q = apbRsp.prdata;
    lastErr = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  // one strobe, then time for flag and irq registers to land
  task automatic pulse(input logic [9:0] v);
    @(posedge mclk);
    fire <= v;
    @(posedge mclk);
    fire <= '0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic stopTest();
    $display("checks=%0d mismatches=%0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    fire = '0;
    apbReq = '0;
    lastErr = 1'b0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < NUM_REGS; i++) begin
      rd(ADDR_MAIN_CONTROL + 16'(i * 16), RESET_VALUE);
    end
    $display("test reset done");
    wr(ADDR_HASH_LOW, 32'hA5A5_0F0F);
    wr(ADDR_HASH_LOW | 16'h0008, 32'h0000_F0F0);
    rd(ADDR_HASH_LOW, 32'hA5A5_FFFF);
    wr(ADDR_HASH_LOW | 16'h0004, 32'hA5A5_0000);
    rd(ADDR_HASH_LOW, 32'h0000_FFFF);
    wr(ADDR_HASH_LOW | 16'h000C, 32'hFFFF_00FF);
    rd(ADDR_HASH_LOW, 32'hFFFF_FF00);
    wr(ADDR_PMASK_LOW, 32'hFFFF_FFFF);
    wr(ADDR_PMASK_LOW | 16'h0004, 32'h0F0F_0F0F);
    rd(ADDR_PMASK_LOW, 32'hF0F0_F0F0);
    wr(ADDR_RX_BUF_SIZE, 32'hFFFF_FFFF);
    rd(ADDR_RX_BUF_SIZE, MASK_RX_BUF_SIZE);
    rd(16'h9100, 32'h0000_0000);
    check({31'h0, lastErr}, 32'h1);
    $display("test alias done");
    // datapath copies: set alias on some, plain writes on others
    wr(ADDR_TX_DESC_START | 16'h0008, 32'hFFFF_FFFF);
    wr(ADDR_RX_DESC_START, 32'hFFFF_FFFF);
    wr(ADDR_PCHECKSUM | 16'h0008, 32'hFFFF_FFFF);
    wr(ADDR_POFFSET, 32'hFFFF_FFFF);
    wr(ADDR_RX_FILTER | 16'h0008, 32'hFFFF_FFFF);
    wr(ADDR_RX_WATERMARKS, 32'hFFFF_FFFF);
    repeat (2) @(posedge mclk);
    check(txDesc, MASK_DESC_START);
    check(rxDesc, MASK_DESC_START);
    check({pCks, pOff}, 32'hFFFF_FFFF);
    check(rxFilt, MASK_RX_FILTER);
    check(rxWmark, MASK_WATERMARKS);
    $display("test outputs done");
    // model bits 0..4 map to flag bits 0,1,2,3,5
    for (int i = 0; i < 5; i++) begin
      b = (i == 4) ? 5 : i;
      pulse(10'(1 << i));
      rd(ADDR_IRQ_REQUEST, 32'(1 << b));
      wr(ADDR_IRQ_REQUEST | 16'h0004, 32'(1 << b));
      rd(ADDR_IRQ_REQUEST, 32'h0000_0000);
    end
    $display("test events done");
    pulse(10'h020);
    pulse(10'h020);
    rd(ADDR_PKT_COUNT, 32'h0000_0002);
    rd(ADDR_IRQ_REQUEST, 32'h0000_00C0);
    wr(ADDR_IRQ_REQUEST | 16'h0004, 32'h0000_0040);
    wr(ADDR_IRQ_REQUEST, 32'h0000_0000);
    rd(ADDR_IRQ_REQUEST, 32'h0000_0040);
    wr(ADDR_MAIN_CONTROL, 32'h0000_0001);
    rd(ADDR_IRQ_REQUEST, 32'h0000_0040);
    wr(ADDR_MAIN_CONTROL, 32'h0000_0001);
    rd(ADDR_IRQ_REQUEST, 32'h0000_0000);
    $display("test pending done");
    wr(ADDR_IRQ_ENABLE, 32'h0000_0008);
    pulse(10'h008);
    check({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_REQUEST | 16'h0004, 32'h0000_0008);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_ENABLE, 32'h0000_0000);
    pulse(10'h008);
    check({31'h0, irq}, 32'h0);
    // pending alone drives the interrupt when its enable is set
    wr(ADDR_IRQ_ENABLE, 32'h0000_0040);
    pulse(10'h020);
    check({31'h0, irq}, 32'h1);
    wr(ADDR_MAIN_CONTROL, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    $display("test irq done");
    stopTest();
  end
endmodule
bind eci_regs eci_regs_checker #(.CountWidth(CountWidth)) u_eci_regs_checker (.mclk(mclk), .rst(rst),
  .apbReq(apbReq), .apbRsp(apbRsp), .mainControl(mainControl), .rxBufSize(rxBufSize),
  .hashTable(hashTable), .patternMask(patternMask), .counterDecPulse(counterDecPulse), .irq(irq));

// ==== src/eci_regs.sv ====
// register bank and interrupt flags of the ethernet controller
// assumes apb master on mclk, event strobes one cycle wide and synchronous to mclk
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
module eci_regs #(
  parameter int CountWidth = eci_pkg::COUNT_WIDTH  // received_packet_counter width
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire eci_pkg::eci_apb_req_t apbReq,
  output      eci_pkg::eci_apb_rsp_t apbRsp,
  input  wire eci_pkg::eci_events_t  events,
  output      logic [31:0]           mainControl,
  output      logic [31:0]           rxBufSize,
  output      logic [31:0]           txDescStart,
  output      logic [31:0]           rxDescStart,
  output      logic [63:0]           hashTable,
  output      logic [63:0]           patternMask,
  output      logic [15:0]           patternChecksum,
  output      logic [15:0]           patternOffset,
  output      logic [31:0]           rxFilterConfig,
  output      logic [31:0]           rxWatermarks,
  output      logic                  counterDecPulse,
  output      logic                  irq
);
  import eci_pkg::*;

  // elaboration-time refusal: the counter view is read through a 16-bit field at most
  if (CountWidth < 1 || CountWidth > 16) begin : g_bad_width
    $error("CountWidth out of range");
  end

  // --------------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------------
  logic [31:0]           regs [NUM_REGS];     // plain storage, request held separately
  logic [31:0]           irqRequest;          // sticky event flags (bit 6 unused here)
  logic [CountWidth-1:0] packetCount;         // received_packet_counter
  logic [31:0]           readMux;             // combinational read data
  logic                  mapped;              // address hits a register
  logic                  accessCycle;         // apb access phase
  logic                  writeStrobe;         // write takes effect this edge
  logic [3:0]            regIndex;            // register picked by address
  logic [1:0]            aliasSel;            // plain, clear, set or invert
  logic                  decrementHit;        // software asks counter to decrement
  logic [31:0]           hwEvents;            // event strobes in flag positions
  logic [31:0]           controlNext;         // main control as this write would leave it

  assign accessCycle = apbReq.psel & apbReq.penable;
  assign writeStrobe = accessCycle & apbReq.pwrite & mapped;
  assign regIndex    = apbReq.paddr[7:4];
  assign aliasSel    = apbReq.paddr[3:2];

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // implemented-bit mask per register index
  function automatic logic [31:0] regMask(input logic [3:0] idx);
    unique case (idx)
      4'h0:          regMask = MASK_MAIN_CONTROL;
      4'h1:          regMask = MASK_RX_BUF_SIZE;
      4'h2, 4'h3:    regMask = MASK_DESC_START;
      4'h4, 4'h5:    regMask = MASK_FULL;
      4'h6, 4'h7:    regMask = MASK_FULL;
      4'h8, 4'h9:    regMask = MASK_LOW_HALF;
      4'hA:          regMask = MASK_RX_FILTER;
      4'hB:          regMask = MASK_WATERMARKS;
      4'hC, 4'hD:    regMask = MASK_IRQ;
      default:       regMask = RESET_VALUE;
    endcase
  endfunction

  // apply plain, clear, set or invert alias to an old value
  function automatic logic [31:0] aliasApply(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [1:0] sel);
    unique case (sel)
      ALIAS_PLAIN:  aliasApply = wd;
      ALIAS_CLEAR:  aliasApply = old & ~wd;
      ALIAS_SET:    aliasApply = old | wd;
      ALIAS_INVERT: aliasApply = old ^ wd;
      default:      aliasApply = old;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  // the counter view has no aliases, so only its plain offset is mapped
  always_comb begin
    mapped = 1'b0;
    if (apbReq.paddr[15:8] == ADDR_MAIN_CONTROL[15:8]) begin
      if (regIndex <= 4'(IDX_IRQ_REQUEST)) begin
        mapped = 1'b1;
      end else if (apbReq.paddr[7:0] == ADDR_PKT_COUNT[7:0]) begin
        mapped = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // software registers other than the request flags
  // --------------------------------------------------------------------------
  // all plain storage, every alias honoured; reset to zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= RESET_VALUE;
      end
    end else if (writeStrobe && regIndex < 4'(IDX_IRQ_REQUEST)) begin
      regs[regIndex] <= aliasApply(regs[regIndex], apbReq.pwdata, aliasSel)
                        & regMask(regIndex);
    end else begin
      // decrement control is a strobe: it never stays set
      regs[IDX_MAIN_CONTROL][BIT_PKT_COUNTER_DEC] <= 1'b0;
    end
  end

  // a write whose result leaves the decrement bit high asks for one decrement
  assign controlNext  = aliasApply(regs[IDX_MAIN_CONTROL], apbReq.pwdata, aliasSel);
  assign decrementHit = writeStrobe && regIndex == 4'(IDX_MAIN_CONTROL)
                        && controlNext[BIT_PKT_COUNTER_DEC];

  // --------------------------------------------------------------------------
  // received packet counter
  // --------------------------------------------------------------------------
  // receive done increments, decrement strobe decrements; both at once cancel unless the count is zero, where receive done increments
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      packetCount <= '0;
    end else begin
      unique case ({events.rxDone, decrementHit && packetCount != '0})
        2'b10: begin
          // saturate: a wrap to zero would drop the pending flag
          if (packetCount != '1) begin
            packetCount <= packetCount + 1'b1;
          end
        end
        2'b01:   packetCount <= packetCount - 1'b1;
        default: packetCount <= packetCount;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // event flags
  // --------------------------------------------------------------------------
  always_comb begin
    hwEvents = '0;
    hwEvents[BIT_RX_OVERFLOW]     = events.rxOverflow;
    hwEvents[BIT_RX_DESC_UNAVAIL] = events.rxDescUnavail;
    hwEvents[BIT_TX_ABORT]        = events.transmit_abort_flag;
    hwEvents[BIT_TX_DONE]         = events.transmit_done_flag;
    hwEvents[BIT_RX_ACTIVITY]     = events.packetStored;
    hwEvents[BIT_RX_DONE]         = events.rxDone;
    hwEvents[BIT_FULL_WATERMARK]  = events.fullWatermark;
    hwEvents[BIT_EMPTY_WATERMARK] = events.emptyWatermark;
    hwEvents[BIT_RX_BUS_ERROR]    = events.rxBusError;
    hwEvents[BIT_TX_BUS_ERROR]    = events.txBusError;
  end

  // sticky flags; a hardware event in the same cycle as a clear wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqRequest <= RESET_VALUE;
    end else if (writeStrobe && regIndex == 4'(IDX_IRQ_REQUEST)) begin
      // pending position is masked out: it follows the counter only
      irqRequest <= (aliasApply(irqRequest, apbReq.pwdata, aliasSel) | hwEvents)
                    & MASK_IRQ & ~(32'h1 << BIT_PACKET_PENDING);
    end else begin
      irqRequest <= irqRequest | hwEvents;
    end
  end

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  always_comb begin
    readMux = RESET_VALUE;
    if (apbReq.paddr[7:0] == ADDR_PKT_COUNT[7:0]) begin
      readMux = 32'(packetCount);
    end else if (regIndex == 4'(IDX_IRQ_REQUEST)) begin
      readMux = irqRequest;
      readMux[BIT_PACKET_PENDING] = (packetCount != '0);
    end else if (regIndex < 4'(IDX_IRQ_REQUEST)) begin
      readMux = regs[regIndex];
    end
  end

  // --------------------------------------------------------------------------
  // apb response: zero wait states, error on unmapped address
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      apbRsp <= '0;
    end else begin
      apbRsp.pready  <= apbReq.psel & ~apbReq.penable;   // ready in the access cycle
      apbRsp.pslverr <= apbReq.psel & ~apbReq.penable & ~mapped;
      apbRsp.prdata  <= (apbReq.psel & ~apbReq.penable & ~apbReq.pwrite & mapped)
                        ? readMux : RESET_VALUE;
    end
  end

  // --------------------------------------------------------------------------
  // outputs to the datapath, all registered
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mainControl     <= RESET_VALUE;
      rxBufSize       <= RESET_VALUE;
      txDescStart     <= RESET_VALUE;
      rxDescStart     <= RESET_VALUE;
      hashTable       <= '0;
      patternMask     <= '0;
      patternChecksum <= '0;
      patternOffset   <= '0;
      rxFilterConfig  <= RESET_VALUE;
      rxWatermarks    <= RESET_VALUE;
      counterDecPulse <= 1'b0;
    end else begin
      mainControl     <= regs[IDX_MAIN_CONTROL];
      rxBufSize       <= regs[IDX_RX_BUF_SIZE];
      txDescStart     <= regs[IDX_TX_DESC];
      rxDescStart     <= regs[IDX_RX_DESC];
      hashTable       <= {regs[ADDR_HASH_HIGH[7:4]], regs[ADDR_HASH_LOW[7:4]]};
      patternMask     <= {regs[ADDR_PMASK_HIGH[7:4]], regs[ADDR_PMASK_LOW[7:4]]};
      patternChecksum <= regs[IDX_PCHECKSUM][15:0];
      patternOffset   <= regs[IDX_POFFSET][15:0];
      rxFilterConfig  <= regs[ADDR_RX_FILTER[7:4]];
      rxWatermarks    <= regs[IDX_RX_WATERMARK];
      counterDecPulse <= decrementHit;
    end
  end

  // interrupt: any request flag with its enable, pending included
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irqRequest | (32'(packetCount != '0) << BIT_PACKET_PENDING))
               & regs[IDX_IRQ_ENABLE]);
    end
  end

endmodule
